// ===== design/csse_consts.svh
// Register map, field positions and counts of the codec slot enable and status block
`ifndef CSSE_CONSTS_SVH
`define CSSE_CONSTS_SVH
`define CSSE_OFF_STAT 8'h00
`define CSSE_OFF_RXMASK 8'h04
`define CSSE_OFF_TXMASK 8'h08
`define CSSE_OFF_CTRL 8'h0c
`define CSSE_OFF_TXDATA 8'h10
`define CSSE_OFF_RXDATA 8'h14
`define CSSE_OFF_IEN 8'h18
`define CSSE_OFF_ISTAT 8'h1c
`define CSSE_OFF_ICLR 8'h20
`define CSSE_STAT_TRANSMIT_EMPTY_FLAG 0
`define CSSE_STAT_TRANSMIT_UNDERFLOW_FLAG 1
`define CSSE_STAT_RECEIVE_FULL_FLAG 2
`define CSSE_STAT_ROV 3
`define CSSE_STAT_SLOT_LO 8
`define CSSE_CTL_ODM 0
`define CSSE_CTL_UFM 1
`define CSSE_CTL_FLS_LO 2
`define CSSE_CTL_BLS_LO 8
`define CSSE_CTL_MASK 16'h033f
`define CSSE_MASK_RST 16'h0000
`define CSSE_CTL_RST 16'h0000
`define CSSE_WORD_LAST 4'hf
`define CSSE_RESP_OKAY 2'b00
`define CSSE_RESP_SLVERR 2'b10
`define CSSE_NEV 4
`define CSSE_DEPTH 4
`endif

// ===== design/csse_pkg.sv
// Types shared by the codec slot enable and status block
package csse_pkg;
    typedef logic [31:0] csse_word_t;
    typedef logic [15:0] csse_half_t;
    typedef logic [1:0] csse_resp_t;
    typedef enum logic {CSSE_IDLE, CSSE_FRAME} csse_lnk_t;
endpackage : csse_pkg

// ===== design/csse_top.sv
// Codec serial port slot enables, holding registers, status and AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "csse_consts.svh"
// What this block does
// - Status bits 11:8 show the active slot index, 0000 to 1111.
// - Status bit 3 is set after any receive holding register overflows.
// - Status bit 2 is set while new receive data fills the holding set.
// - Status bit 1 is set after any transmit holding register underflows.
// - Status bit 0 is set while the transmit holding registers are empty.
// - Status is read only, resets to 0001 (only transmit empty set), unimplemented bits read zero.
// - Slot n input is captured only when receive enable bit n is set.
// - Slot n shifts out transmit buffer contents when transmit enable n is set.
// - Disabled transmit slots float or drive zero per the output mode bit.
// - Both slot enable masks are 16-bit read/write, resetting to zero.
// - Output mode 1 floats disabled slots; mode 0 drives zeros.
// - On underflow send last written word if fill mode is 1, else zeros.
// - A frame holds frame length field plus one words, 1 to 16.
// - Buffer length field sets one to four words between interrupts.
module csse_top (
    input wire logic sys_clk, // Block clock, 250 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire csse_pkg::csse_word_t awaddr, // Write byte address
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    input wire csse_pkg::csse_word_t wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    output csse_pkg::csse_resp_t bresp, // Write response
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    input wire csse_pkg::csse_word_t araddr, // Read byte address
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    output csse_pkg::csse_word_t rdata, // Read data
    output csse_pkg::csse_resp_t rresp, // Read response
    input wire logic serial_clk, // Link bit clock from the codec
    input wire logic frame_sync, // Frame sync from the codec
    input wire logic serial_data_in, // Serial data from the codec
    output logic serial_data_out, // Serial data to the codec
    output logic serial_data_out_oe_n, // Output enable, low while driving
    output logic irq // Level interrupt
);
    import csse_pkg::*;

    function automatic logic known_addr(input logic [31:0] a);
        known_addr = (a[31:8] == 24'h0) && (a[1:0] == 2'b00) && (a[7:0] <= `CSSE_OFF_ICLR);
    endfunction : known_addr

    function automatic csse_half_t merge16(input csse_half_t old, input csse_word_t d,
                                           input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // Link inputs cross into sys_clk through two flops each
    logic sck_p_q;
    logic sck_a_q, sck_b_q, fs_a_q, fs_b_q, sdi_a_q, sdi_b_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sck_a_q <= 1'b0;
            sck_b_q <= 1'b0;
            sck_p_q <= 1'b0;
            fs_a_q <= 1'b0;
            fs_b_q <= 1'b0;
            sdi_a_q <= 1'b0;
            sdi_b_q <= 1'b0;
        end else begin
            sck_a_q <= serial_clk;
            sck_b_q <= sck_a_q;
            sck_p_q <= sck_b_q;
            fs_a_q <= frame_sync;
            fs_b_q <= fs_a_q;
            sdi_a_q <= serial_data_in;
            sdi_b_q <= sdi_a_q;
        end
    end
    wire sck_rise = sck_b_q & ~sck_p_q;
    wire sck_fall = ~sck_b_q & sck_p_q;

    // Registers
    csse_half_t rxmask_q, txmask_q, ctrl_q;
    logic [`CSSE_NEV-1:0] ien_q, ist_q, ev_set;
    wire odm = ctrl_q[`CSSE_CTL_ODM];
    wire ufm = ctrl_q[`CSSE_CTL_UFM];
    wire [3:0] fls = ctrl_q[`CSSE_CTL_FLS_LO +: 4];
    wire [2:0] nbuf = {1'b0, ctrl_q[`CSSE_CTL_BLS_LO +: 2]} + 3'd1;

    // Holding registers, storage in flops indexed by pointers
    csse_half_t tx_buf_q [`CSSE_DEPTH];
    csse_half_t rx_buf_q [`CSSE_DEPTH];
    csse_half_t last_q;
    logic [1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [2:0] tx_cnt_q, rx_cnt_q;

    // Link state
    csse_lnk_t lnk_q;
    logic [3:0] slot_q, bit_q;
    csse_half_t rx_sh_q, tx_sh_q;
    logic sdo_q, sdo_oe_n_q;

    // Bus slave state
    logic awready_q, wready_q, aw_got_q, w_got_q, bvalid_q, arready_q, rvalid_q;
    logic [31:0] aw_addr_q;
    csse_word_t w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    csse_resp_t bresp_q, rresp_q;
    logic irq_q;

    wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
    wire [7:0] wa = aw_addr_q[7:0];
    wire wr_ok = known_addr(aw_addr_q);
    wire rd_fire = arvalid & arready_q;
    wire rd_ok = known_addr(araddr);
    wire rd_pop = rd_fire & rd_ok & (araddr[7:0] == `CSSE_OFF_RXDATA) & (rx_cnt_q != 3'd0);

    // Transmit side: software pushes, link pops at each enabled slot start
    wire tx_push = wr_fire & wr_ok & (wa == `CSSE_OFF_TXDATA) & (tx_cnt_q != nbuf);
    wire word_start = (lnk_q == CSSE_FRAME) & sck_fall & (bit_q == 4'h0);
    wire slot_tx_en = txmask_q[slot_q];
    wire tx_pop = word_start & slot_tx_en & (tx_cnt_q != 3'd0);
    wire tx_unf = word_start & slot_tx_en & (tx_cnt_q == 3'd0);
    wire [15:0] tx_word = tx_pop ? tx_buf_q[tx_rp_q] : (ufm ? last_q : 16'h0000);

    // Receive side: link pushes at each enabled slot's word end, software pops by reading
    wire word_end = (lnk_q == CSSE_FRAME) & sck_rise & ~fs_b_q & (bit_q == `CSSE_WORD_LAST);
    wire rx_take = word_end & rxmask_q[slot_q];
    wire rx_ovf = rx_take & (rx_cnt_q == nbuf);
    wire rx_push = rx_take & ~rx_ovf;
    wire [15:0] rx_word = {rx_sh_q[14:0], sdi_b_q};

    wire [2:0] tx_cnt_d = tx_cnt_q + {2'b00, tx_push} - {2'b00, tx_pop};
    wire [2:0] rx_cnt_d = rx_cnt_q + {2'b00, rx_push} - {2'b00, rd_pop};

    // Events raise on entry to empty/full so each buffered set interrupts once
    assign ev_set[`CSSE_STAT_TRANSMIT_EMPTY_FLAG] = tx_pop & (tx_cnt_d == 3'd0);
    assign ev_set[`CSSE_STAT_TRANSMIT_UNDERFLOW_FLAG] = tx_unf;
    assign ev_set[`CSSE_STAT_RECEIVE_FULL_FLAG] = rx_push & (rx_cnt_d == nbuf);
    assign ev_set[`CSSE_STAT_ROV] = rx_ovf;
    wire [3:0] iclr = (wr_fire & wr_ok & (wa == `CSSE_OFF_ICLR)) ? w_data_q[3:0] : 4'h0;

    wire [15:0] stat_w = {4'h0, slot_q, 4'h0, ist_q[`CSSE_STAT_ROV],
                          (rx_cnt_q == nbuf), ist_q[`CSSE_STAT_TRANSMIT_UNDERFLOW_FLAG], (tx_cnt_q == 3'd0)};

    wire [15:0] rd_mux =
        (araddr[7:0] == `CSSE_OFF_STAT) ? stat_w :
        (araddr[7:0] == `CSSE_OFF_RXMASK) ? rxmask_q :
        (araddr[7:0] == `CSSE_OFF_TXMASK) ? txmask_q :
        (araddr[7:0] == `CSSE_OFF_CTRL) ? ctrl_q :
        (araddr[7:0] == `CSSE_OFF_RXDATA) ? rx_buf_q[rx_rp_q] :
        (araddr[7:0] == `CSSE_OFF_IEN) ? {12'h000, ien_q} :
        (araddr[7:0] == `CSSE_OFF_ISTAT) ? {12'h000, ist_q} : 16'h0000;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rxmask_q <= `CSSE_MASK_RST;
            txmask_q <= `CSSE_MASK_RST;
            ctrl_q <= `CSSE_CTL_RST;
            ien_q <= 4'h0;
        end else if (wr_fire & wr_ok) begin
            if (wa == `CSSE_OFF_RXMASK) rxmask_q <= merge16(rxmask_q, w_data_q, w_strb_q);
            if (wa == `CSSE_OFF_TXMASK) txmask_q <= merge16(txmask_q, w_data_q, w_strb_q);
            if (wa == `CSSE_OFF_CTRL) ctrl_q <= merge16(ctrl_q, w_data_q, w_strb_q) & `CSSE_CTL_MASK;
            if (wa == `CSSE_OFF_IEN && w_strb_q[0]) ien_q <= w_data_q[3:0];
        end
    end

    // Sticky status: a set in the same cycle as its clear wins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ist_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            ist_q <= (ist_q & ~iclr) | ev_set;
            irq_q <= |(ist_q & ien_q);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_wp_q <= 2'b00;
            tx_rp_q <= 2'b00;
            rx_wp_q <= 2'b00;
            rx_rp_q <= 2'b00;
            tx_cnt_q <= 3'd0;
            rx_cnt_q <= 3'd0;
            last_q <= 16'h0000;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            rx_cnt_q <= rx_cnt_d;
            if (tx_push) begin
                tx_wp_q <= tx_wp_q + 2'b01;
                last_q <= w_data_q[15:0];
            end
            if (tx_pop) tx_rp_q <= tx_rp_q + 2'b01;
            if (rx_push) rx_wp_q <= rx_wp_q + 2'b01;
            if (rd_pop) rx_rp_q <= rx_rp_q + 2'b01;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CSSE_DEPTH; gi++) begin : g_buf
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    tx_buf_q[gi] <= 16'h0000;
                    rx_buf_q[gi] <= 16'h0000;
                end else begin
                    if (tx_push && tx_wp_q == gi) tx_buf_q[gi] <= w_data_q[15:0];
                    if (rx_push && rx_wp_q == gi) rx_buf_q[gi] <= rx_word;
                end
            end
        end
    endgenerate

    // Link counters: frame sync seen on a bit clock rise restarts the frame
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lnk_q <= CSSE_IDLE;
            slot_q <= 4'h0;
            bit_q <= 4'h0;
            rx_sh_q <= 16'h0000;
        end else if (sck_rise && fs_b_q) begin
            lnk_q <= CSSE_FRAME;
            slot_q <= 4'h0;
            bit_q <= 4'h0;
        end else if (sck_rise && lnk_q == CSSE_FRAME) begin
            rx_sh_q <= rx_word;
            bit_q <= bit_q + 4'h1;
            if (word_end) slot_q <= (slot_q == fls) ? 4'h0 : slot_q + 4'h1;
        end
    end

    // Output changes on the bit clock fall, codec samples on the rise
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_sh_q <= 16'h0000;
            sdo_q <= 1'b0;
            sdo_oe_n_q <= 1'b1;
        end else if (word_start) begin
            tx_sh_q <= slot_tx_en ? tx_word : 16'h0000;
            sdo_q <= slot_tx_en ? tx_word[15] : 1'b0;
            sdo_oe_n_q <= ~slot_tx_en & odm;
        end else if (sck_fall && lnk_q == CSSE_FRAME) begin
            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
            sdo_q <= tx_sh_q[14];
        end
    end

    // AXI4-Lite: one write and one read at a time, address and data in any order
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `CSSE_RESP_OKAY;
        end else begin
            if (awvalid && awready_q) begin
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready_q) begin
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `CSSE_RESP_OKAY : `CSSE_RESP_SLVERR;
            end
            if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `CSSE_RESP_OKAY;
        end else if (rd_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_ok ? rd_mux : 16'h0000};
            rresp_q <= rd_ok ? `CSSE_RESP_OKAY : `CSSE_RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign serial_data_out = sdo_q;
    assign serial_data_out_oe_n = sdo_oe_n_q;
    assign irq = irq_q;

    // Checks
    stat_slot_a: assert property (@(posedge sys_clk) disable iff (reset)
        rd_fire && rd_ok && araddr[7:0] == `CSSE_OFF_STAT
        |=> rdata_q[11:8] == $past(slot_q) && rdata_q[31:12] == 20'h0 && rdata_q[7:4] == 4'h0)
        else $error("status slot field or reserved bits wrong");
    rx_ovf_a: assert property (@(posedge sys_clk) disable iff (reset)
        rx_take && rx_cnt_q == nbuf |=> ist_q[`CSSE_STAT_ROV] && $stable(rx_wp_q))
        else $error("receive overflow not flagged");
    rx_full_a: assert property (@(posedge sys_clk) disable iff (reset)
        rx_push && rx_cnt_q + 3'd1 == nbuf && !rd_pop |=> stat_w[`CSSE_STAT_RECEIVE_FULL_FLAG])
        else $error("receive full not shown");
    tx_unf_a: assert property (@(posedge sys_clk) disable iff (reset)
        tx_unf |=> ist_q[`CSSE_STAT_TRANSMIT_UNDERFLOW_FLAG] ##1 ist_q[`CSSE_STAT_TRANSMIT_UNDERFLOW_FLAG] || $past(iclr[1]))
        else $error("transmit underflow not flagged");
    tx_empty_a: assert property (@(posedge sys_clk) disable iff (reset)
        tx_push && !tx_pop |=> !stat_w[`CSSE_STAT_TRANSMIT_EMPTY_FLAG])
        else $error("transmit empty flag stuck");
    rx_ignore_a: assert property (@(posedge sys_clk) disable iff (reset)
        word_end && !rxmask_q[slot_q] && !rd_pop |=> $stable(rx_cnt_q))
        else $error("disabled slot was captured");
    tx_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
        word_start && slot_tx_en |=> !sdo_oe_n_q && sdo_q == $past(tx_word[15]))
        else $error("enabled slot not driven");
    tx_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
        word_start && !slot_tx_en |=> sdo_oe_n_q == $past(odm) && !sdo_q)
        else $error("disabled slot output mode wrong");
    mask_rst_a: assert property (@(posedge sys_clk) disable iff (reset)
        $past(reset) |-> rxmask_q == `CSSE_MASK_RST && txmask_q == `CSSE_MASK_RST)
        else $error("slot masks not reset");
    unf_fill_a: assert property (@(posedge sys_clk) disable iff (reset)
        tx_unf |=> tx_sh_q == ($past(ufm) ? $past(last_q) : 16'h0000))
        else $error("underflow fill word wrong");
    frame_wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
        word_end && slot_q == fls |=> slot_q == 4'h0)
        else $error("frame length wrap wrong");
    buf_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
        rx_cnt_q <= nbuf || $past(ctrl_q) != ctrl_q)
        else $error("receive count exceeds buffer length");
    frame_start_a: assert property (@(posedge sys_clk) disable iff (reset)
        sck_rise && fs_b_q |=> slot_q == 4'h0 && bit_q == 4'h0)
        else $error("frame sync did not restart slot");
    cov_unf_c: cover property (@(posedge sys_clk) disable iff (reset) tx_unf && ufm);
    cov_ovf_c: cover property (@(posedge sys_clk) disable iff (reset) rx_ovf);
    cov_wrap_c: cover property (@(posedge sys_clk) disable iff (reset) word_end && slot_q == 4'hf);
    cov_irq_c: cover property (@(posedge sys_clk) disable iff (reset) $rose(irq_q));
endmodule : csse_top
`default_nettype wire

// ===== tb/csse_codec_model.sv
// Behavioural codec on the far side of the framed serial link
`timescale 1ns/1ns
`default_nettype none
module csse_codec_model (
    output logic serial_clk, // Bit clock, still between frames
    output logic frame_sync, // High for one bit period at frame start
    output logic serial_data_in, // Data towards the block
    input wire logic serial_data_out, // Data from the block
    input wire logic serial_data_out_oe_n // Low while the block drives
);
    logic [15:0] send_w [0:15];
    logic [15:0] got_w [0:15];
    logic float_w [0:15];
    initial begin
        serial_clk = 1'b0;
        frame_sync = 1'b0;
        serial_data_in = 1'b0;
    end
    // Half periods of 63 and 62 ns make the 125 ns bit clock
    task automatic run_frame(input int nw);
        frame_sync = 1'b1;
        #63 serial_clk = 1'b1;
        for (int w = 0; w < nw; w++) begin
            float_w[w] = 1'b1;
            for (int b = 15; b >= 0; b--) begin
                #62 serial_clk = 1'b0;
                frame_sync = 1'b0;
                serial_data_in = send_w[w][b];
                #63 got_w[w][b] = serial_data_out;
                float_w[w] = float_w[w] & serial_data_out_oe_n;
                serial_clk = 1'b1;
            end
        end
        #62 serial_clk = 1'b0;
        // Released line shows the inverse so a stale bit cannot pass
        serial_data_in = ~serial_data_in;
    endtask : run_frame
endmodule : csse_codec_model
`default_nettype wire

// ===== tb/tb_codec_slot_enable_status.sv
// Self-checking bench: register traffic and framed link scenarios
`timescale 1ns/1ns
`default_nettype none
`include "csse_consts.svh"
module tb_codec_slot_enable_status;
    import csse_pkg::*;
    logic sys_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, irq;
    logic arvalid, arready, rvalid, rready, serial_clk, frame_sync, serial_data_in;
    logic serial_data_out, serial_data_out_oe_n;
    csse_word_t awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    csse_resp_t bresp, rresp;
    logic [33:0] exp_q [$];
    int mismatches, n_tests, cycles;
    logic [15:0] lf;

    csse_top csse_top_inst (
        .sys_clk(sys_clk), .reset(reset), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .serial_clk(serial_clk), .frame_sync(frame_sync),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe_n(serial_data_out_oe_n), .irq(irq)
    );
    csse_codec_model csse_codec_model_inst (
        .serial_clk(serial_clk), .frame_sync(frame_sync), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Whole run needs about 5000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            results();
        end
    end

    // Responses are compared against the oldest note left by the driver
    always @(posedge sys_clk) begin
        if (bvalid && bready) begin
            check({bresp, 32'h0}, exp_q.pop_front());
        end
        if (rvalid && rready) begin
            check({rresp, rdata}, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input csse_resp_t er);
        exp_q.push_back({er, 32'h0});
        @(posedge sys_clk);
        awvalid <= 1'b1;
        awaddr <= {24'h0, a};
        wvalid <= 1'b1;
        wdata <= {16'h0, d};
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] d, input csse_resp_t er);
        exp_q.push_back({er, 16'h0, d});
        @(posedge sys_clk);
        arvalid <= 1'b1;
        araddr <= {24'h0, a};
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic frame3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        csse_codec_model_inst.send_w[0] = a;
        csse_codec_model_inst.send_w[1] = b;
        csse_codec_model_inst.send_w[2] = c;
        csse_codec_model_inst.run_frame(3);
        // Covers the link synchroniser delay
        repeat (8) @(posedge sys_clk);
    endtask : frame3

    // A floating slot is expected with data field zero
    task automatic chk_word(input int w, input logic [15:0] d, input logic f);
        logic fl;
        fl = csse_codec_model_inst.float_w[w];
        check({17'h0, fl, fl ? 16'h0 : csse_codec_model_inst.got_w[w]}, {17'h0, f, d});
    endtask : chk_word

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        wstrb = 4'hf;
        reset = 1'b1;
        lf = 16'h0016;
        cycles = 0;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`CSSE_OFF_STAT, 16'h0001, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_RXMASK, `CSSE_MASK_RST, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_TXMASK, `CSSE_MASK_RST, `CSSE_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            wr(`CSSE_OFF_RXMASK, lf, `CSSE_RESP_OKAY);
            rd(`CSSE_OFF_RXMASK, lf, `CSSE_RESP_OKAY);
            lf = lfsr(lf);
            wr(`CSSE_OFF_TXMASK, lf, `CSSE_RESP_OKAY);
            rd(`CSSE_OFF_TXMASK, lf, `CSSE_RESP_OKAY);
        end
        wr(8'h24, 16'h1234, `CSSE_RESP_SLVERR);
        rd(8'h24, 16'h0000, `CSSE_RESP_SLVERR);
        $display("Test done: register access");
        // Four-word frames, two-word buffer, floating idle slots, repeat fill
        wr(`CSSE_OFF_CTRL, 16'h010f, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_CTRL, 16'h010f, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_IEN, 16'h0002, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_RXMASK, 16'h0002, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_TXMASK, 16'h0001, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_TXDATA, 16'ha5c3, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_STAT, 16'h0000, `CSSE_RESP_OKAY);
        frame3(16'h1111, 16'h3c5a, 16'h7777);
        chk_word(0, 16'ha5c3, 1'b0);
        chk_word(1, 16'h0000, 1'b1);
        chk_word(2, 16'h0000, 1'b1);
        rd(`CSSE_OFF_STAT, 16'h0301, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_RXDATA, 16'h3c5a, `CSSE_RESP_OKAY);
        check({33'h0, irq}, 34'h0);
        $display("Test done: first frame");
        // Drive zeros in idle slots, underflow repeats the last word
        wr(`CSSE_OFF_CTRL, 16'h010e, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_RXMASK, 16'h0003, `CSSE_RESP_OKAY);
        frame3(16'h1234, 16'h5678, 16'h9abc);
        chk_word(0, 16'ha5c3, 1'b0);
        chk_word(1, 16'h0000, 1'b0);
        rd(`CSSE_OFF_STAT, 16'h0307, `CSSE_RESP_OKAY);
        check({33'h0, irq}, 34'h1);
        rd(`CSSE_OFF_RXDATA, 16'h1234, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_RXDATA, 16'h5678, `CSSE_RESP_OKAY);
        $display("Test done: underflow repeat");
        // Zero fill on underflow, three words into a two-word buffer
        wr(`CSSE_OFF_CTRL, 16'h010c, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_RXMASK, 16'h0007, `CSSE_RESP_OKAY);
        frame3(16'h0f0f, 16'hf00d, 16'h4321);
        chk_word(0, 16'h0000, 1'b0);
        rd(`CSSE_OFF_STAT, 16'h030f, `CSSE_RESP_OKAY);
        wr(`CSSE_OFF_ICLR, 16'h000f, `CSSE_RESP_OKAY);
        rd(`CSSE_OFF_STAT, 16'h0305, `CSSE_RESP_OKAY);
        check({33'h0, irq}, 34'h0);
        $display("Test done: overflow and clear");
        results();
    end
endmodule : tb_codec_slot_enable_status
`default_nettype wire
